/* ebc_bus_agent.sv */
// ebc_bus_agent: far-side model issuing external cycle requests
`timescale 1ns/1ps
module ebc_bus_agent (
    // clock and bench command
    input  wire logic        hclk,
    input  wire logic        req,
    input  wire logic [23:0] req_addr,
    // toward the bank
    output logic             cycle_start,
    output logic [23:0]      cycle_addr
);
    // outside a request the address toggles so a stale latch cannot look fresh
    always_ff @(posedge hclk) begin
        cycle_start <= req;
        cycle_addr  <= req ? req_addr : ~cycle_addr;
    end
endmodule : ebc_bus_agent

/* ebc_config_regs.sv */
// ebc_config_regs: external bus configuration register bank with ahb-lite slave
// Contract
// - outside all windows use default config
// - configs one to four pair with windows
// - share bit lets master reach peripherals
// - visible bit mirrors peripheral accesses externally
// - serial enable selects upper port pins
// - write config strapped; splits write strobes
// - clock output enable drives clock pin
// - high byte disable frees byte pin
// - rom enable strapped; zero sends external
// - segmentation disable saves pointer only
// - stack size field selects 32..1024 words
// - system config locked after end init
// - default config preset from straps
// - default active from strap, latch long
// - no ready: waits are 15 minus field
// - delay bit zero delays command half clock
// - tristate bit zero adds one wait
// - type field selects width and multiplexing
// - active bit enables bus per window
// - ready enable hands termination to ready
// - select enable ties select to command
// - window holds size and start fields
// - latch lengthen bit stretches latch pulse
// - ready mode: low bits wait, top async
// - size codes 4k doubling; 11xx reserved
// - window two over one, four over three
`timescale 1ns/1ps
module ebc_config_regs
    import ebc_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // ahb-lite slave
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // straps and cpu events
    input  wire logic [7:0]        strap_port,
    input  wire logic              external_access_strap_n,
    input  wire logic              wide_bus_strap,
    input  wire logic              end_init_instruction,
    // external cycle request
    input  wire logic              cycle_start,
    input  wire logic [ADDR_W-1:0] cycle_addr,
    // system controls
    output logic                   periph_share_bit,
    output logic                   periph_visible_bit,
    output logic                   serial_port_enable_bit,
    output logic                   low_byte_write_mode,
    output logic                   clock_output_enable_bit,
    output logic                   byte_high_enable_pin_free,
    output logic                   internal_rom_enable_bit,
    output logic                   rom_mapping_bit,
    output logic                   save_code_segment_pointer,
    output logic [10:0]            stack_words,
    // parameters of the current external cycle
    output logic [2:0]             cycle_window,
    output logic                   cycle_bus_enabled,
    output logic [3:0]             cycle_waitstates,
    output logic                   cycle_ready_used,
    output logic                   cycle_ready_async,
    output logic                   cycle_cmd_delayed,
    output logic                   cycle_tristate_wait,
    output logic                   cycle_wide_bus,
    output logic                   cycle_multiplexed,
    output logic                   cycle_latch_long,
    output logic                   cycle_rd_select_gated,
    output logic                   cycle_wr_select_gated
);
    // ==================== synchronisers ====================
    // no reset on these stages: the straps must already sit in the second stage
    // when reset lifts, since they are taken at the very first edge after it
    logic [7:0]  strap_s1_r, strap_s2_r;
    logic        ext_s1_r, ext_s2_r, wide_s1_r, wide_s2_r;
    always_ff @(posedge hclk) begin
        strap_s1_r <= strap_port;
        strap_s2_r <= strap_s1_r;
        ext_s1_r   <= external_access_strap_n;
        ext_s2_r   <= ext_s1_r;
        wide_s1_r  <= wide_bus_strap;
        wide_s2_r  <= wide_s1_r;
    end

    // ==================== ahb address phase ====================
    logic        wr_pend_r, rd_pend_r;
    logic [7:0]  addr_q_r;
    logic        sc_hit_r;
    wire         take      = hsel && hready && htrans[1];
    wire  [7:0]  data_addr = addr_q_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_q_r  <= 8'h00;
            sc_hit_r  <= 1'b0;
        end else begin
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
            if (take) begin
                addr_q_r <= haddr[7:0];
                sc_hit_r <= (haddr[15:0] == OFF_SYSTEM_CONFIG);
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==================== registers ====================
    logic [15:0] sys_cfg_r;
    logic [15:0] bus_cfg_r [0:4];
    logic [15:0] win_r     [1:4];
    logic        init_done_r;
    logic        strap_pending_r;
    wire  [15:0] wdata = hwdata[15:0];
    // the mirror offset lets software reach the system register from the low map
    wire  sc_wr = wr_pend_r && (sc_hit_r || data_addr == OFF_SYS_CFG_LOCAL) && !init_done_r;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [15:0] msk);
        merge = (old & ~msk) | (nw & msk);
    endfunction : merge

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_cfg_r       <= 16'h0000;
            init_done_r     <= 1'b0;
            strap_pending_r <= 1'b1;
        end else begin
            strap_pending_r <= 1'b0;
            if (strap_pending_r) begin
                // straps are taken right after release, after synchronisation
                sys_cfg_r[SC_WRITE_CFG]     <= strap_s2_r[0];
                sys_cfg_r[SC_ROM_EN]        <= ext_s2_r;
                sys_cfg_r[SC_HIGH_BYTE_DIS] <= !wide_s2_r;
            end else if (sc_wr) begin
                sys_cfg_r <= merge(sys_cfg_r, wdata, SC_WRITE_MASK);
            end
            if (end_init_instruction || (wr_pend_r && data_addr == OFF_INIT_DONE && wdata[0]))
                init_done_r <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_bc
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    bus_cfg_r[gi] <= (gi == 0) ? {6'h00, 1'b1, 9'h00f} | BC_RESET : BC_RESET;
                end else if (gi == 0 && strap_pending_r) begin
                    bus_cfg_r[gi][BC_BUS_ACTIVE]            <= !ext_s2_r;
                    bus_cfg_r[gi][BC_LATCH_LONG]            <= 1'b1;
                    bus_cfg_r[gi][BC_TYPE_LSB +: 2]         <= strap_s2_r[7:6];
                end else if (wr_pend_r && !sc_hit_r && data_addr == OFF_BUS_CYCLE_CFG0 + 8'(4*gi)) begin
                    bus_cfg_r[gi] <= merge(bus_cfg_r[gi], wdata, BC_WRITE_MASK);
                end
            end
        end
        for (gi = 1; gi < 5; gi++) begin : g_aw
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn)
                    win_r[gi] <= AW_RESET;
                else if (wr_pend_r && !sc_hit_r && data_addr == OFF_ADDR_WINDOW1 + 8'(4*(gi-1)))
                    win_r[gi] <= wdata;
            end
        end
    endgenerate

    // ==================== window decode ====================
    // size code n frees address bits 12 to 11+n; codes 11xx never match
    function automatic logic win_hit(input logic [15:0] w, input logic [ADDR_W-1:0] a);
        logic [11:0] msk;
        logic [3:0]  sz;
        sz  = w[AW_SIZE_LSB +: 4];
        msk = 12'hfff << sz;
        win_hit = (sz[3:2] != 2'b11) &&
                  (((a[ADDR_W-1 -: 12] ^ w[AW_START_LSB +: 12]) & msk) == 12'h000);
    endfunction : win_hit

    wire hit1 = win_hit(win_r[1], cycle_addr);
    wire hit2 = win_hit(win_r[2], cycle_addr);
    wire hit3 = win_hit(win_r[3], cycle_addr);
    wire hit4 = win_hit(win_r[4], cycle_addr);
    // overlap between the two groups is unsupported; group one is checked first
    wire [2:0] sel_win = hit2 ? 3'd2 : hit1 ? 3'd1 :
                         hit4 ? 3'd4 : hit3 ? 3'd3 : 3'd0;
    wire [15:0] sel_cfg = bus_cfg_r[sel_win];

    // ==================== cycle latch ====================
    // parameters freeze at cycle start so a mid-cycle write waits for the next one
    logic [15:0] cyc_cfg_r;
    logic [2:0]  cyc_win_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_cfg_r <= BC_RESET;
            cyc_win_r <= 3'd0;
        end else if (cycle_start) begin
            cyc_cfg_r <= sel_cfg;
            cyc_win_r <= sel_win;
        end
    end
    wire [3:0] cyc_field = cyc_cfg_r[BC_CYCLE_LSB +: 4];
    assign cycle_window          = cyc_win_r;
    assign cycle_bus_enabled     = cyc_cfg_r[BC_BUS_ACTIVE];
    assign cycle_ready_used      = cyc_cfg_r[BC_READY_EN];
    assign cycle_waitstates      = cycle_ready_used ? {1'b0, cyc_field[2:0]}
                                                    : CYCLE_WAIT_MAX - cyc_field;
    assign cycle_ready_async     = cycle_ready_used && cyc_field[3];
    assign cycle_cmd_delayed     = !cyc_cfg_r[BC_CMD_DELAY];
    assign cycle_tristate_wait   = !cyc_cfg_r[BC_TRISTATE];
    assign cycle_wide_bus        = cyc_cfg_r[BC_TYPE_LSB + 1];
    assign cycle_multiplexed     = cyc_cfg_r[BC_TYPE_LSB];
    assign cycle_latch_long      = cyc_cfg_r[BC_LATCH_LONG];
    assign cycle_rd_select_gated = cyc_cfg_r[BC_RD_SEL_EN];
    assign cycle_wr_select_gated = cyc_cfg_r[BC_WR_SEL_EN];

    // ==================== system outputs ====================
    assign periph_share_bit          = sys_cfg_r[SC_PERIPH_SHARE];
    assign periph_visible_bit        = sys_cfg_r[SC_VISIBLE];
    assign serial_port_enable_bit    = sys_cfg_r[SC_SERIAL_EN];
    assign low_byte_write_mode       = sys_cfg_r[SC_WRITE_CFG];
    assign clock_output_enable_bit   = sys_cfg_r[SC_CLOCK_OUTPUT_PIN_EN];
    assign byte_high_enable_pin_free = sys_cfg_r[SC_HIGH_BYTE_DIS];
    assign internal_rom_enable_bit   = sys_cfg_r[SC_ROM_EN];
    assign rom_mapping_bit           = sys_cfg_r[SC_ROM_MAP];
    assign save_code_segment_pointer = !sys_cfg_r[SC_SEG_DIS];
    // code k gives 32 << k words, capped at the largest stack
    wire [2:0] stk = sys_cfg_r[SC_STACK_LSB +: 3];
    assign stack_words = (stk > 3'd5) ? 11'(STACK_WORDS_MAX)
                                      : 11'(STACK_WORDS_MIN) << stk;

    // ==================== read mux ====================
    // decoded in the address phase so the word stands through the whole data phase;
    // limitation: a read right behind a write to the same register sees the old word
    wire        rd_sys  = (haddr[15:0] == OFF_SYSTEM_CONFIG) ||
                          (haddr[7:0] == OFF_SYS_CFG_LOCAL);
    wire [7:0]  rd_addr = haddr[7:0];
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (rd_sys) rd_val = sys_cfg_r;
        else if (rd_addr == OFF_INIT_DONE)  rd_val = {15'h0000, init_done_r};
        else if (rd_addr == OFF_CYCLE_STATUS) rd_val = {13'h0000, cyc_win_r};
        else if (rd_addr <= OFF_BUS_CYCLE_CFG4 && rd_addr[1:0] == 2'b00)
            rd_val = bus_cfg_r[rd_addr[4:2]];
        else if (rd_addr <= OFF_ADDR_WINDOW4 && rd_addr[1:0] == 2'b00)
            rd_val = win_r[3'(rd_addr[5:2] - 4'd4)];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)              hrdata <= 32'h0000_0000;
        else if (take && !hwrite)  hrdata <= {16'h0000, rd_val};
    end
endmodule : ebc_config_regs

/* ebc_config_regs_asserts.sv */
// ebc_config_regs_asserts: port-level checker for the configuration bank
`timescale 1ns/1ps
module ebc_config_regs_asserts (
    // bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // straps and events
    input wire logic [7:0]  strap_port,
    input wire logic        external_access_strap_n,
    input wire logic        wide_bus_strap,
    input wire logic        end_init_instruction,
    input wire logic        cycle_start,
    // controls
    input wire logic        periph_share_bit,
    input wire logic        periph_visible_bit,
    input wire logic        serial_port_enable_bit,
    input wire logic        low_byte_write_mode,
    input wire logic        clock_output_enable_bit,
    input wire logic        byte_high_enable_pin_free,
    input wire logic        internal_rom_enable_bit,
    input wire logic [10:0] stack_words,
    input wire logic [2:0]  cycle_window,
    input wire logic [3:0]  cycle_waitstates,
    input wire logic        cycle_ready_used
);
    // ==================== helpers ====================
    logic locked_r;
    wire logic wr_acc;
    assign wr_acc = hsel && hready && htrans[1] && hwrite;
    // lock is sticky until reset, like the end of initialisation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) locked_r <= 1'b0;
        else if (end_init_instruction) locked_r <= 1'b1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==================== properties ====================
    sequence sys_moved;
        $changed({periph_share_bit, periph_visible_bit, serial_port_enable_bit,
                  clock_output_enable_bit, stack_words});
    endsequence
    sequence straps_seen;
        internal_rom_enable_bit == external_access_strap_n
        && byte_high_enable_pin_free == !wide_bus_strap
        && low_byte_write_mode == strap_port[0];
    endsequence
    bus_resp_okay_a: assert property (hreadyout && !hresp && hrdata[31:16] == 16'h0000)
        else $error("bus answer not okay or upper data nonzero");
    rdata_hold_a: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
        else $error("read data moved without a transfer");
    strap_load_a: assert property ($rose(hresetn) |-> ##2 straps_seen)
        else $error("strapped bits differ from straps");
    sys_lock_a: assert property (sys_moved |-> $past(wr_acc, 2) && !locked_r)
        else $error("system controls moved without an unlocked write");
    cycle_hold_a: assert property ($changed({cycle_window, cycle_waitstates,
        cycle_ready_used}) |-> $past(cycle_start)) else $error("cycle set changed off start");
    stack_range_a: assert property ($onehot(stack_words) && stack_words >= 11'h020)
        else $error("stack size outside range");
    window_range_a: assert property (cycle_window <= 3'h4)
        else $error("window number out of range");
    ready_waits_a: assert property (cycle_ready_used |-> cycle_waitstates <= 4'h7)
        else $error("ready cycle uses top cycle bit as wait");
endmodule : ebc_config_regs_asserts
bind ebc_config_regs ebc_config_regs_asserts i_chk (.*);

/* ebc_config_regs_tb.sv */
// ebc_config_regs_tb: self-checking bench for the configuration bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ebc_config_regs_tb;
    import ebc_pkg::*;
    // ==================== signals ====================
    logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req = 1'b0;
    logic        end_init_instruction = 1'b0, external_access_strap_n = 1'b0;
    logic        wide_bus_strap = 1'b1, cycle_start, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, cycle_window;
    logic [3:0]  cycle_waitstates;
    logic [7:0]  strap_port = 8'hc1;
    logic [10:0] stack_words;
    logic [23:0] req_addr = 24'h00_0000, cycle_addr;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic        periph_share_bit, periph_visible_bit, serial_port_enable_bit;
    logic        low_byte_write_mode, clock_output_enable_bit, byte_high_enable_pin_free;
    logic        internal_rom_enable_bit, rom_mapping_bit, save_code_segment_pointer;
    logic        cycle_bus_enabled, cycle_ready_used, cycle_ready_async, cycle_cmd_delayed;
    logic        cycle_tristate_wait, cycle_wide_bus, cycle_multiplexed, cycle_latch_long;
    logic        cycle_rd_select_gated, cycle_wr_select_gated;
    wire logic   hready;
    wire logic [13:0] cyc_vec;
    wire logic [19:0] sys_vec;
    int          n_mismatch = 0, n_checks = 0, n_cyc = 0;
    assign hready  = hreadyout;
    assign cyc_vec = {cycle_waitstates, cycle_ready_used, cycle_ready_used & cycle_ready_async,
        cycle_cmd_delayed, cycle_tristate_wait, cycle_wide_bus, cycle_multiplexed,
        cycle_latch_long, cycle_bus_enabled, cycle_rd_select_gated, cycle_wr_select_gated};
    assign sys_vec = {periph_share_bit, periph_visible_bit, serial_port_enable_bit,
        low_byte_write_mode, clock_output_enable_bit, byte_high_enable_pin_free,
        internal_rom_enable_bit, rom_mapping_bit, save_code_segment_pointer, stack_words};
    ebc_config_regs i_dut (.*);
    ebc_bus_agent i_agent (.hclk(hclk), .req(req), .req_addr(req_addr),
        .cycle_start(cycle_start), .cycle_addr(cycle_addr));
    // ==================== expectations ====================
    function automatic logic [13:0] cyc_exp(input logic [15:0] v);
        logic [3:0] ws;
        ws = v[12] ? {1'b0, v[2:0]} : 4'hf - v[3:0];
        return {ws, v[12], v[12] & v[3], ~v[4], ~v[5], v[7], v[6], v[9], v[10], v[14], v[15]};
    endfunction : cyc_exp
    function automatic logic [19:0] sys_exp(input logic [15:0] v);
        logic [10:0] sw;
        sw = (v[15:13] > 3'h5) ? 11'h400 : 11'h020 << v[15:13];
        return {v[0], v[1], v[2], v[7], v[8], v[9], v[10], v[12], ~v[11], sw};
    endfunction : sys_exp
    // ==================== bus and cycle tasks ====================
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic ahb(input logic w, input logic [31:0] a, input logic [15:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic rc(input logic [31:0] a, input logic [15:0] e);
        ahb(1'b0, a, 16'h0000, rd);
        `CHK(rd, {16'h0000, e})
    endtask : rc
    task automatic cyc(input logic [23:0] a);
        @(posedge hclk);
        req      <= 1'b1;
        req_addr <= a;
        @(posedge hclk);
        req <= 1'b0;
        @(posedge hclk);
        #1;
    endtask : cyc
    // ==================== scenarios ====================
    task automatic t_reset(input logic [7:0] sp, input logic en, input logic wb);
        logic [15:0] b0;
        b0 = {5'h00, ~en, 2'h2, sp[7:6], 6'h0f};
        strap_port              <= sp;
        external_access_strap_n <= en;
        wide_bus_strap          <= wb;
        hresetn                 <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rc(32'h0000_0000, b0);
        rc(32'h0000_0024, {5'h00, en, ~wb, 1'b0, sp[0], 7'h00});
        rc(32'h0000_0014, 16'h0000);
        rc(32'h0000_0030, 16'h0000);
        cyc(24'h7f_0000);
        `CHK(cycle_window, 3'h0)
        `CHK(cyc_vec, cyc_exp(b0))
    endtask : t_reset
    task automatic t_fields();
        logic [15:0] tv [5] = '{16'h0000, 16'h4675, 16'h908c, 16'h10c3, 16'hffff};
        ahb(1'b1, 32'h0000_0014, 16'h2000, rd);
        foreach (tv[i]) begin
            ahb(1'b1, 32'h0000_0004, tv[i], rd);
            rc(32'h0000_0004, tv[i] & BC_WRITE_MASK);
            cyc(24'h20_0abc);
            `CHK(cyc_vec, cyc_exp(tv[i] & BC_WRITE_MASK))
        end
    endtask : t_fields
    task automatic t_windows();
        logic [23:0] wa [8] = '{24'h10_0000, 24'h10_1fff, 24'h10_3fff, 24'h10_4000,
                               24'h90_0010, 24'h90_ffff, 24'h91_0000, 24'h7f_ffff};
        logic [2:0]  we [8] = '{3'h1, 3'h2, 3'h1, 3'h0, 3'h4, 3'h4, 3'h3, 3'h0};
        ahb(1'b1, 32'h0000_0014, 16'h1002, rd);
        ahb(1'b1, 32'h0000_0018, 16'h1010, rd);
        ahb(1'b1, 32'h0000_001c, 16'h800b, rd);
        ahb(1'b1, 32'h0000_0020, 16'h90f4, rd);
        rc(32'h0000_0020, 16'h90f4);
        foreach (wa[i]) begin
            cyc(wa[i]);
            `CHK(cycle_window, we[i])
        end
        rc(32'h0000_002c, 16'h0000);
        ahb(1'b1, 32'h0000_0014, 16'h100c, rd);
        cyc(24'h10_0000);
        `CHK(cycle_window, 3'h0)
    endtask : t_windows
    task automatic t_lock(input logic [15:0] e);
        ahb(1'b1, 32'h0000_0028, 16'h0001, rd);
        rc(32'h0000_0028, 16'h0001);
        ahb(1'b1, 32'h0000_0024, 16'hffff, rd);
        rc(32'h0000_0024, e);
    endtask : t_lock
    task automatic t_sys();
        logic [15:0] sv [3] = '{16'hffff, 16'h4000, 16'h0000};
        foreach (sv[i]) begin
            ahb(1'b1, i[0] ? 32'h0000_ff12 : 32'h0000_0024, sv[i], rd);
            rc(32'h0000_ff12, sv[i] & SC_WRITE_MASK);
            `CHK(sys_vec, sys_exp(sv[i] & SC_WRITE_MASK))
        end
        @(posedge hclk) end_init_instruction <= 1'b1;
        @(posedge hclk) end_init_instruction <= 1'b0;
        ahb(1'b1, 32'h0000_0024, 16'hffff, rd);
        rc(32'h0000_0024, 16'h0000);
    endtask : t_sys
    // ==================== run ====================
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // a hang is cut short well beyond the under two hundred cycles the run needs
    always @(posedge hclk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        t_reset(8'hc1, 1'b0, 1'b1);
        t_fields();
        t_windows();
        t_sys();
        t_reset(8'h40, 1'b1, 1'b0);
        t_lock(16'h0600);
        close_out();
    end
endmodule : ebc_config_regs_tb

/* ebc_pkg.sv */
// ebc_pkg: register map, field layout and reset values of the external bus configuration bank
package ebc_pkg;
    // ==================== register byte offsets ====================
    localparam logic [15:0] OFF_SYSTEM_CONFIG    = 16'hff12;
    localparam logic [7:0]  OFF_BUS_CYCLE_CFG0   = 8'h00;
    localparam logic [7:0]  OFF_BUS_CYCLE_CFG1   = 8'h04;
    localparam logic [7:0]  OFF_BUS_CYCLE_CFG2   = 8'h08;
    localparam logic [7:0]  OFF_BUS_CYCLE_CFG3   = 8'h0c;
    localparam logic [7:0]  OFF_BUS_CYCLE_CFG4   = 8'h10;
    localparam logic [7:0]  OFF_ADDR_WINDOW1     = 8'h14;
    localparam logic [7:0]  OFF_ADDR_WINDOW2     = 8'h18;
    localparam logic [7:0]  OFF_ADDR_WINDOW3     = 8'h1c;
    localparam logic [7:0]  OFF_ADDR_WINDOW4     = 8'h20;
    localparam logic [7:0]  OFF_SYS_CFG_LOCAL    = 8'h24;
    localparam logic [7:0]  OFF_INIT_DONE        = 8'h28;
    localparam logic [7:0]  OFF_CYCLE_STATUS     = 8'h2c;
    // ==================== system config fields ====================
    localparam int SC_PERIPH_SHARE  = 0;
    localparam int SC_VISIBLE       = 1;
    localparam int SC_SERIAL_EN     = 2;
    localparam int SC_WRITE_CFG     = 7;
    localparam int SC_CLOCK_OUTPUT_PIN_EN     = 8;
    localparam int SC_HIGH_BYTE_DIS = 9;
    localparam int SC_ROM_EN        = 10;
    localparam int SC_SEG_DIS       = 11;
    localparam int SC_ROM_MAP       = 12;
    localparam int SC_STACK_LSB     = 13;
    localparam logic [15:0] SC_WRITE_MASK = 16'hfb87;
    // ==================== bus cycle config fields ====================
    localparam int BC_CYCLE_LSB     = 0;
    localparam int BC_CMD_DELAY     = 4;
    localparam int BC_TRISTATE      = 5;
    localparam int BC_TYPE_LSB      = 6;
    localparam int BC_LATCH_LONG    = 9;
    localparam int BC_BUS_ACTIVE    = 10;
    localparam int BC_READY_EN      = 12;
    localparam int BC_RD_SEL_EN     = 14;
    localparam int BC_WR_SEL_EN     = 15;
    localparam logic [15:0] BC_WRITE_MASK = 16'hd6ff;
    localparam logic [15:0] BC_RESET      = 16'h0000;
    // ==================== address window fields ====================
    localparam int AW_SIZE_LSB      = 0;
    localparam int AW_START_LSB     = 4;
    localparam logic [15:0] AW_RESET      = 16'h0000;
    // ==================== timing and stack size ====================
    localparam logic [3:0]  CYCLE_WAIT_MAX = 4'hf;
    localparam int          STACK_WORDS_MAX = 1024;
    localparam int          STACK_WORDS_MIN = 32;
endpackage : ebc_pkg
